// ---- hw/ifs_sequencer.sv ----
// Purpose: Interpolator config and start/stop frame sequencer behind a Wishbone slave.
// Assumes: frame_done_i comes from logic on clk_i; one clock, synchronous reset.
// Notes: Each frame is two 16-bit words of storage; frame k uses words 2k and 2k+1.
`timescale 1ns/10ps

module ifs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // One extra pointer bit tells full from empty without a counter
  assign empty_o = (wr_q == rd_q);
  assign full_o = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready_o = !full_o;
  assign out_valid_o = !empty_o;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = in_valid_i && !full_o;
  assign pop = out_ready_i && !empty_o;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (pop) begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end
endmodule // ifs_fifo

// Overview of operation
// - Factor code 0..14 selects times 4..65536.
// - Factor in bits 12-15; multiplier 2^(code+2).
// - Frame count holds 1 to 128 frames.
// - Execution starts at frame 0, ends count-1.
// - After last frame reload 0; auto-restart decides.
// - Pointer selects frame storage word 0..255.
// - Pointer auto-increments on frame data access.
module ifs_sequencer #(
  parameter int WORD_W = 16,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [16:0] interp_mult_o,
  output logic swap_channels_o,
  output logic running_o,
  output logic [6:0] frame_index_o,
  output logic frame_valid_o,
  input wire logic frame_ready_i,
  output logic [WORD_W-1:0] frame_word_o,
  input wire logic frame_done_i
);
  logic [15:0] store_q [256];
  logic ack_q;
  logic [31:0] dat_q;
  logic [3:0] factor_q;
  logic auto_q;
  logic swap_q;
  logic [16:0] mult_q;
  logic [7:0] count_q;
  logic [7:0] ptr_q;
  ifs_pkg::ifs_mode_e mode_q;
  ifs_pkg::ifs_state_e state_q;
  logic [6:0] frame_q;
  logic word_q;
  logic req;
  logic acc;
  logic wr;
  logic [7:0] idx;
  logic [15:0] wmask;
  logic [15:0] rdata;
  logic start;
  logic last;
  logic finish;
  logic fifo_ready;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic [15:0] cnt_wr;

  assign req = cyc_i && stb_i;
  // Writes and pointer side effects act on the edge where ack is sampled
  assign acc = req && ack_q;
  assign wr = acc && we_i;
  assign idx = adr_i[9:2];
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign cnt_wr = (dat_i[15:0] & wmask) | ({8'h00, count_q} & ~wmask);

  always_comb begin
    rdata = 16'h0000;
    case (idx)
      ifs_pkg::IDX_CONFIG: begin
        rdata[ifs_pkg::CFG_FACTOR_MSB:ifs_pkg::CFG_FACTOR_LSB] = factor_q;
        rdata[ifs_pkg::CFG_SWAP_BIT] = swap_q;
        rdata[ifs_pkg::CFG_AUTO_BIT] = auto_q;
      end
      ifs_pkg::IDX_FRAME_COUNT: rdata = {8'h00, count_q};
      ifs_pkg::IDX_FRAME_PTR: rdata = {8'h00, ptr_q};
      ifs_pkg::IDX_MODE: rdata = {14'h0000, mode_q};
      ifs_pkg::IDX_FRAME_DATA: rdata = store_q[ptr_q];
      ifs_pkg::IDX_STATUS: begin
        rdata[ifs_pkg::ST_RUN_BIT] = (state_q != ifs_pkg::IFS_ST_IDLE);
        rdata[ifs_pkg::ST_EMPTY_BIT] = fifo_empty;
        rdata[ifs_pkg::ST_FULL_BIT] = fifo_full;
        rdata[ifs_pkg::ST_FRAME_LSB +: 7] = frame_q;
      end
      default: rdata = 16'h0000;
    endcase
  end

  // Classic slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        dat_q <= {16'h0000, rdata};
      end
    end
  end

  // Code 15 is outside the table, so such a write leaves the factor as it was
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      factor_q <= ifs_pkg::FACTOR_RST;
      auto_q <= 1'b0;
      swap_q <= 1'b0;
    end else if (wr && idx == ifs_pkg::IDX_CONFIG) begin
      if (sel_i[1] && dat_i[ifs_pkg::CFG_FACTOR_MSB:ifs_pkg::CFG_FACTOR_LSB] <= ifs_pkg::FACTOR_MAX) begin
        factor_q <= dat_i[ifs_pkg::CFG_FACTOR_MSB:ifs_pkg::CFG_FACTOR_LSB];
      end
      if (sel_i[0]) begin
        auto_q <= dat_i[ifs_pkg::CFG_AUTO_BIT];
        swap_q <= dat_i[ifs_pkg::CFG_SWAP_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mult_q <= ifs_pkg::MULT_RST;
    end else begin
      mult_q <= 17'h00001 << (5'(factor_q) + ifs_pkg::MULT_SHIFT_BASE);
    end
  end

  // Out-of-range counts are clamped so the sequencer never sees 0 or >128
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= ifs_pkg::FRAME_COUNT_RST;
    end else if (wr && idx == ifs_pkg::IDX_FRAME_COUNT) begin
      if (cnt_wr < ifs_pkg::FRAME_COUNT_MIN) begin
        count_q <= ifs_pkg::FRAME_COUNT_MIN[7:0];
      end else if (cnt_wr > ifs_pkg::FRAME_COUNT_MAX) begin
        count_q <= ifs_pkg::FRAME_COUNT_MAX[7:0];
      end else begin
        count_q <= cnt_wr[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= ifs_pkg::FRAME_PTR_RST;
    end else if (wr && idx == ifs_pkg::IDX_FRAME_PTR && sel_i[0]) begin
      ptr_q <= dat_i[7:0];
    end else if (acc && idx == ifs_pkg::IDX_FRAME_DATA) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && idx == ifs_pkg::IDX_FRAME_DATA) begin
      store_q[ptr_q] <= (dat_i[15:0] & wmask) | (store_q[ptr_q] & ~wmask);
    end
  end

  // A host write to the mode wins over the sequencer dropping back to idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= ifs_pkg::IFS_MODE_IDLE;
    end else if (wr && idx == ifs_pkg::IDX_MODE && sel_i[0] && dat_i[1:0] != 2'h3) begin
      mode_q <= ifs_pkg::ifs_mode_e'(dat_i[1:0]);
    end else if (finish && !auto_q) begin
      mode_q <= ifs_pkg::IFS_MODE_IDLE;
    end
  end

  assign start = (state_q == ifs_pkg::IFS_ST_IDLE) && (mode_q == ifs_pkg::IFS_MODE_RUN);
  assign last = ({1'b0, frame_q} == count_q - 8'h01);
  assign finish = (state_q == ifs_pkg::IFS_ST_WAIT) && (mode_q == ifs_pkg::IFS_MODE_RUN)
                  && frame_done_i && last;
  assign push = (state_q == ifs_pkg::IFS_ST_FEED) && (mode_q == ifs_pkg::IFS_MODE_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ifs_pkg::IFS_ST_IDLE;
      frame_q <= 7'h00;
      word_q <= 1'b0;
    end else begin
      case (state_q)
        ifs_pkg::IFS_ST_IDLE: begin
          if (start) begin
            frame_q <= 7'h00;
            word_q <= 1'b0;
            state_q <= ifs_pkg::IFS_ST_FEED;
          end
        end
        ifs_pkg::IFS_ST_FEED: begin
          if (mode_q != ifs_pkg::IFS_MODE_RUN) begin
            state_q <= ifs_pkg::IFS_ST_IDLE;
          end else if (fifo_ready) begin
            word_q <= !word_q;
            if (word_q) begin
              state_q <= ifs_pkg::IFS_ST_WAIT;
            end
          end
        end
        ifs_pkg::IFS_ST_WAIT: begin
          if (mode_q != ifs_pkg::IFS_MODE_RUN) begin
            state_q <= ifs_pkg::IFS_ST_IDLE;
          end else if (frame_done_i) begin
            word_q <= 1'b0;
            if (last) begin
              frame_q <= 7'h00;
              state_q <= auto_q ? ifs_pkg::IFS_ST_FEED : ifs_pkg::IFS_ST_IDLE;
            end else begin
              frame_q <= frame_q + 7'h01;
              state_q <= ifs_pkg::IFS_ST_FEED;
            end
          end
        end
        default: state_q <= ifs_pkg::IFS_ST_IDLE;
      endcase
    end
  end

  // Stopping flushes queued words so a restart never replays stale frames
  ifs_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(mode_q != ifs_pkg::IFS_MODE_RUN),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(WORD_W'(store_q[{frame_q, word_q}])),
    .out_valid_o(frame_valid_o),
    .out_ready_i(frame_ready_i),
    .out_data_o(frame_word_o),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  assign interp_mult_o = mult_q;
  assign swap_channels_o = swap_q;
  assign running_o = (state_q != ifs_pkg::IFS_ST_IDLE);
  assign frame_index_o = frame_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  factor_range_a: assert property (factor_q <= ifs_pkg::FACTOR_MAX)
    else $error("interpolation factor code above 14");
  mult_value_a: assert property (##1 interp_mult_o == (17'h00001 << (5'($past(factor_q)) + 5'h02)))
    else $error("multiplier does not match factor code");
  count_range_a: assert property (count_q >= 8'h01 && count_q <= 8'h80)
    else $error("frame count outside 1 to 128");
  start_frame_a: assert property (start |=> state_q == ifs_pkg::IFS_ST_FEED && frame_q == 7'h00)
    else $error("execution did not start at frame 0");
  frame_step_a: assert property ((state_q == ifs_pkg::IFS_ST_WAIT && mode_q == ifs_pkg::IFS_MODE_RUN
      && frame_done_i && !last) |=> frame_q == $past(frame_q) + 7'h01)
    else $error("frame did not advance by one");
  restart_a: assert property ((finish && auto_q) |=> frame_q == 7'h00 ##0 running_o ##1 push)
    else $error("auto restart did not reload frame 0");
  halt_a: assert property ((finish && !auto_q && !wr) |=> frame_q == 7'h00 && !running_o
      && mode_q == ifs_pkg::IFS_MODE_IDLE)
    else $error("sequencer did not stop after last frame");
  data_store_a: assert property ((wr && idx == ifs_pkg::IDX_FRAME_DATA && sel_i[1:0] == 2'b11)
      |=> store_q[$past(ptr_q)] == $past(dat_i[15:0]))
    else $error("frame data not stored at pointer");
  ptr_step_a: assert property ((acc && idx == ifs_pkg::IDX_FRAME_DATA) |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not step after data access");
  ptr_hold_a: assert property (!(acc && (idx == ifs_pkg::IDX_FRAME_DATA || idx == ifs_pkg::IDX_FRAME_PTR))
      |=> $stable(ptr_q))
    else $error("pointer moved without an access");

  fifo_full_c: cover property (fifo_full && !frame_ready_i);
  auto_wrap_c: cover property (finish && auto_q);
  stop_wrap_c: cover property (finish && !auto_q);
  ptr_wrap_c: cover property (acc && idx == ifs_pkg::IDX_FRAME_DATA && ptr_q == 8'hff);
endmodule // ifs_sequencer

// ---- hw/ifs_pkg.sv ----
// Purpose: Shared constants for the interpolator and start/stop frame sequencer.
// Assumes: Word registers on a 32-bit Wishbone bus, byte address = 4 * index.
// Notes: Register values are 16 bits wide and sit in the low half of the word.
package ifs_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CONFIG = 8'hd0;
  localparam logic [7:0] IDX_FRAME_COUNT = 8'hd1;
  localparam logic [7:0] IDX_FRAME_PTR = 8'hd2;
  localparam logic [7:0] IDX_MODE = 8'hd3;
  localparam logic [7:0] IDX_FRAME_DATA = 8'hd4;
  localparam logic [7:0] IDX_STATUS = 8'hd5;

  // Config word fields
  localparam int CFG_AUTO_BIT = 0;
  localparam int CFG_SWAP_BIT = 1;
  localparam int CFG_FACTOR_LSB = 12;
  localparam int CFG_FACTOR_MSB = 15;
  localparam logic [3:0] FACTOR_MAX = 4'he;
  localparam logic [4:0] MULT_SHIFT_BASE = 5'h02;

  // Status word fields
  localparam int ST_RUN_BIT = 15;
  localparam int ST_EMPTY_BIT = 14;
  localparam int ST_FULL_BIT = 13;
  localparam int ST_FRAME_LSB = 0;

  // Frame count limits and reset values
  localparam logic [15:0] FRAME_COUNT_MIN = 16'h0001;
  localparam logic [15:0] FRAME_COUNT_MAX = 16'h0080;
  localparam logic [7:0] FRAME_COUNT_RST = 8'h01;
  localparam logic [7:0] FRAME_PTR_RST = 8'h00;
  localparam logic [3:0] FACTOR_RST = 4'h0;
  localparam logic [16:0] MULT_RST = 17'h00004;

  typedef enum logic [1:0] {
    IFS_MODE_IDLE = 2'h0,
    IFS_MODE_LOAD = 2'h1,
    IFS_MODE_RUN = 2'h2
  } ifs_mode_e;

  typedef enum logic [1:0] {
    IFS_ST_IDLE = 2'b00,
    IFS_ST_FEED = 2'b01,
    IFS_ST_WAIT = 2'b11
  } ifs_state_e;

endpackage

// ---- test/ifs_consumer.sv ----
// Purpose: Frame stream consumer model standing at the sequencer's far side.
// Assumes: Same clock as the sequencer; a word is taken on valid and ready.
// Notes: Eager mode holds done high so the FIFO fills while the model stalls.
`timescale 1ns/10ps
module ifs_consumer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic eager_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic done_o
);
  logic odd_q;
  logic done_q;
  logic tick_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odd_q <= 1'b0;
      done_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= ~tick_q;
      // The odd word closes a frame, so done follows one cycle after its pop
      done_q <= valid_i && ready_o && odd_q;
      if (valid_i && ready_o) begin
        odd_q <= ~odd_q;
      end
    end
  end
  // Slow mode takes a word only every other cycle
  assign ready_o = !stall_i && (!slow_i || tick_q);
  assign done_o = done_q || eager_i;
endmodule // ifs_consumer

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the interpolator config and frame sequencer.
// Assumes: Wishbone ack one cycle after a request; consumer model on the stream.
// Notes: Read and frame word expectations are queued and checked by a monitor.
`timescale 1ns/10ps
module tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, run_o, fv_o, fr_rdy, fr_done;
  logic stall, slow, eager, swap_o;
  logic [6:0] fidx;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [16:0] mult_o;
  logic [15:0] fw_o;
  logic [31:0] rd_q[$];
  logic [15:0] fr_q[$];
  logic [15:0] mem[256];
  int n_mismatch, samples_checked, seed, i, k;

  ifs_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .interp_mult_o(mult_o), .swap_channels_o(swap_o), .running_o(run_o), .frame_index_o(fidx),
    .frame_valid_o(fv_o), .frame_ready_i(fr_rdy), .frame_word_o(fw_o), .frame_done_i(fr_done));
  ifs_consumer cons (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
    .eager_i(eager), .valid_i(fv_o), .ready_o(fr_rdy), .done_o(fr_done));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches=%0d checked=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Request held until ack is sampled high, then released for a cycle
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {16'h0000, d};
    @(posedge clk_i);
    // Only the watchdog ends a wait for ack
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    rd_q.push_back({16'h0000, e});
    bus(1'b0, idx, 16'h0000);
  endtask

  task automatic drain();
    k = 0;
    while (fr_q.size() != 0 && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (fr_q.size() != 0) n_mismatch++;
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) chk(dat_o, rd_q.pop_front());
    if (fv_o === 1'b1 && fr_rdy === 1'b1 && fr_q.size() > 0)
      chk({16'h0000, fw_o}, {16'h0000, fr_q.pop_front()});
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    seed = 39;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, stall, slow, eager} = 6'h00;
    adr_i = 10'h000;
    sel_i = 4'h3;
    dat_i = 32'h00000000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ifs_pkg::IDX_CONFIG, 16'h0000);
    rd(ifs_pkg::IDX_FRAME_COUNT, 16'h0001);
    rd(ifs_pkg::IDX_FRAME_PTR, 16'h0000);
    rd(8'h10, 16'h0000);
    for (i = 0; i <= 15; i++) begin
      wr(ifs_pkg::IDX_CONFIG, 16'(i) << 12);
      repeat (2) @(posedge clk_i);
      chk({15'h0000, mult_o}, 32'h1 << ((i < 15 ? i : 14) + 2));
    end
    rd(ifs_pkg::IDX_CONFIG, 16'he000);
    wr(ifs_pkg::IDX_CONFIG, 16'he002);
    @(posedge clk_i);
    chk({31'h0, swap_o}, 32'h1);
    rd(ifs_pkg::IDX_CONFIG, 16'he002);
    wr(ifs_pkg::IDX_FRAME_COUNT, 16'h0000);
    rd(ifs_pkg::IDX_FRAME_COUNT, 16'h0001);
    wr(ifs_pkg::IDX_FRAME_COUNT, 16'h00c8);
    rd(ifs_pkg::IDX_FRAME_COUNT, 16'h0080);
    wr(ifs_pkg::IDX_FRAME_PTR, 16'h00fe);
    for (i = 0; i < 4; i++) begin
      k = $random(seed);
      mem[8'(254 + i)] = k[15:0];
      wr(ifs_pkg::IDX_FRAME_DATA, k[15:0]);
    end
    rd(ifs_pkg::IDX_FRAME_PTR, 16'h0002);
    wr(ifs_pkg::IDX_FRAME_PTR, 16'h00fe);
    for (i = 0; i < 4; i++) rd(ifs_pkg::IDX_FRAME_DATA, mem[8'(254 + i)]);
    rd(ifs_pkg::IDX_FRAME_PTR, 16'h0002);
    wr(ifs_pkg::IDX_FRAME_COUNT, 16'h0005);
    wr(ifs_pkg::IDX_MODE, 16'h0001);
    wr(ifs_pkg::IDX_FRAME_PTR, 16'h0000);
    for (i = 0; i < 10; i++) begin
      k = $random(seed);
      mem[i] = k[15:0];
      fr_q.push_back(k[15:0]);
      wr(ifs_pkg::IDX_FRAME_DATA, k[15:0]);
    end
    wr(ifs_pkg::IDX_CONFIG, 16'h0000);
    stall <= 1'b1;
    eager <= 1'b1;
    wr(ifs_pkg::IDX_MODE, 16'h0002);
    repeat (40) @(posedge clk_i);
    // Frames 0..3 fill all eight places; frame 4 waits for room
    rd(ifs_pkg::IDX_STATUS, 16'ha004);
    chk({25'h0, fidx}, 32'h4);
    // Eager done runs ahead of the stream, so abort and replay with a real consumer
    wr(ifs_pkg::IDX_MODE, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk({30'h0, run_o, fv_o}, 32'h0);
    fr_q.delete();
    stall <= 1'b0;
    eager <= 1'b0;
    for (i = 0; i < 10; i++) fr_q.push_back(mem[i]);
    wr(ifs_pkg::IDX_MODE, 16'h0002);
    drain();
    repeat (10) @(posedge clk_i);
    chk({31'h0, run_o}, 32'h0);
    chk({25'h0, fidx}, 32'h0);
    rd(ifs_pkg::IDX_MODE, 16'h0000);
    rd(ifs_pkg::IDX_STATUS, 16'h4000);
    wr(ifs_pkg::IDX_FRAME_COUNT, 16'h0002);
    wr(ifs_pkg::IDX_CONFIG, 16'h0001);
    for (i = 0; i < 12; i++) fr_q.push_back(mem[i % 4]);
    slow <= 1'b1;
    wr(ifs_pkg::IDX_MODE, 16'h0002);
    drain();
    chk({31'h0, run_o}, 32'h1);
    wr(ifs_pkg::IDX_MODE, 16'h0000);
    rd(ifs_pkg::IDX_MODE, 16'h0000);
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule // tb
